/* File: hdl/dq_ref_pkg.sv */
// Purpose: Shared constants and types for the data reference level mode register.
// Assumes: Mode register address is 6 bits, data is 8 bits.
// Notes: Level percentages are kept in tenths of a percent.
package dq_ref_pkg;
  localparam logic [5:0] DQ_REF_CTRL_ADDR = 6'h0E;
  localparam logic [5:0] LEVEL_CODE_MAX = 6'h32;
  localparam logic [5:0] LEVEL_CODE_RESET = 6'h0D;
  localparam logic RANGE_RESET = 1'b1;
  localparam int RANGE_BIT = 6;
  localparam int RESERVED_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h4D;
  // Tenths of a percent of the output supply
  localparam logic [9:0] RANGE0_BASE_TENTHS = 10'h064;
  localparam logic [9:0] RANGE1_BASE_TENTHS = 10'h0DC;
  localparam logic [9:0] STEP_TENTHS = 10'h004;

  typedef struct packed {
    logic range_sel;
    logic [5:0] level;
  } ref_cfg_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } mr_cmd_s;
endpackage : dq_ref_pkg

/* File: hdl/dq_ref_level_decode.sv */
// Purpose: Turns an active level code and range into a supply fraction.
// Assumes: Inputs come from flip-flops on the same clock.
// Notes: Reserved codes flag as invalid and give the range base.
`timescale 1ns/10ps
module dq_ref_level_decode (
  // Active configuration
  input wire dq_ref_pkg::ref_cfg_s cfg,
  // Decoded level
  output logic [9:0] level_tenths,
  output logic code_valid
);
  import dq_ref_pkg::*;

  // Base plus 0.4 % per code step
  always_comb begin
    code_valid = (cfg.level <= LEVEL_CODE_MAX);
    level_tenths = cfg.range_sel ? RANGE1_BASE_TENTHS : RANGE0_BASE_TENTHS;
    if (code_valid) begin
      level_tenths = level_tenths + 10'({4'h0, cfg.level} * STEP_TENTHS);
    end
  end
endmodule : dq_ref_level_decode

/* File: hdl/dq_reference_level_ctrl.sv */
// Purpose: Banked mode register for the data-bus input reference level.
// Assumes: Commands arrive synchronous to clock, one per cycle at most.
// Notes: Set-point selects come from the companion set-point control register.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Low six bits hold level; codes above 0x32 reserved
// - Bit six selects range; range 1 default
// - Read drives stored bits onto data lines
// - Reserved bit and unused lines read zero
// - Write-point select picks copy for writes
// - Two copies; access touches only selected copy
// - Operating-point copy drives the active configuration
// - Inactive copy ignored; may change freely
// - Range bit held until rewrite or reset
// - Range 0 spans 10.0 to 30.0 percent
// - Range 1 spans 22.0 to 42.0 percent
module dq_reference_level_ctrl #(
  // Banked copies; the one-bit selects can address two
  parameter int NUM_COPIES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  // Mode register command
  input wire dq_ref_pkg::mr_cmd_s cmd,
  // Set-point selects from the set-point control register
  input wire logic write_set_point_select,
  input wire logic operating_set_point_select,
  // Read answer
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Active reference configuration
  output dq_ref_pkg::ref_cfg_s active_cfg,
  output logic [9:0] active_level_tenths,
  output logic active_code_valid
);
  import dq_ref_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check: the selects are single bits, so only two copies fit
  if (NUM_COPIES != 2) begin : g_copies_check
    $error("dq_reference_level_ctrl: NUM_COPIES must be 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  ref_cfg_s copy_reg [NUM_COPIES];
  ref_cfg_s copy_next [NUM_COPIES];
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  ref_cfg_s active_reg, active_next;

  function automatic logic hit(input mr_cmd_s c);
    hit = (c.addr == DQ_REF_CTRL_ADDR);
  endfunction : hit

  // Bank write; only the copy named by the write select moves
  always_comb begin
    copy_next = copy_reg;
    if (cmd.wr_en && hit(cmd)) begin
      copy_next[write_set_point_select] = ref_cfg_s'(cmd.wdata[6:0]);
    end
  end

  // Read answer from the write-selected copy, bit 7 forced low
  always_comb begin
    rd_valid_next = cmd.rd_en && hit(cmd);
    rd_data_next = 8'h00;
    if (rd_valid_next) begin
      rd_data_next = {1'b0, copy_reg[write_set_point_select]};
    end
  end

  // Active configuration follows only the operating copy
  always_comb begin
    active_next = copy_reg[operating_set_point_select];
  end

  // Register all state; reset loads default into both copies
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      copy_reg[0] <= ref_cfg_s'(REG_RESET[6:0]);
      copy_reg[1] <= ref_cfg_s'(REG_RESET[6:0]);
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      active_reg <= ref_cfg_s'(REG_RESET[6:0]);
    end else if (clk_en) begin
      copy_reg <= copy_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      active_reg <= active_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign active_cfg = active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Fraction decode kept apart so the analog side can reuse it
  dq_ref_level_decode u_decode (
    .cfg(active_reg),
    .level_tenths(active_level_tenths),
    .code_valid(active_code_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // A plain read, checked once for each copy
  property p_read(bit sel);
    @(posedge clock) disable iff (!rstn)
      (clk_en && cmd.rd_en && hit(cmd) && !cmd.wr_en && write_set_point_select == sel)
      |=> rd_valid && rd_data == {1'b0, copy_reg[sel]};
  endproperty

  // Read path: the answer is the copy picked by the write select
  a_read_copy0: assert property (p_read(1'b0)) else $error("read copy0 mismatch");
  a_read_copy1: assert property (p_read(1'b1)) else $error("read copy1 mismatch");
  // Bit 7 has no storage, so a read must never show it set
  a_read_bit7_zero: assert property (@(posedge clock) disable iff (!rstn)
    rd_data[RESERVED_BIT] == 1'b0) else $error("reserved bit set");
  // Outside a pulse the data lines rest at zero
  a_idle_zero: assert property (@(posedge clock) disable iff (!rstn)
    !rd_valid |-> rd_data == 8'h00) else $error("idle data not zero");
  // No taken read, no pulse; a stuck valid would hand the controller stale data
  a_read_pulse: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && !(cmd.rd_en && hit(cmd))) |=> !rd_valid)
    else $error("read pulse without read");

  // Write path: the selected copy takes the byte without bit 7
  a_write_sel: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && cmd.wr_en && hit(cmd))
    |=> copy_reg[$past(write_set_point_select)] == ref_cfg_s'($past(cmd.wdata[6:0])))
    else $error("write missed copy");
  // The other copy keeps its contents through that write
  a_other_hold: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && cmd.wr_en && hit(cmd))
    |=> copy_reg[!$past(write_set_point_select)] == $past(copy_reg[!write_set_point_select]))
    else $error("unselected copy changed");
  // Range bits move only on a write to this address
  a_range_hold: assert property (@(posedge clock) disable iff (!rstn)
    !(cmd.wr_en && hit(cmd))
    |=> $stable(copy_reg[0].range_sel) && $stable(copy_reg[1].range_sel))
    else $error("range changed without write");

  // Per copy: a copy moves only on a taken write aimed at it
  // This also covers a frozen enable, where no write is taken at all
  for (genvar g = 0; g < NUM_COPIES; g++) begin : g_copy_chk
    a_copy_untouched: assert property (@(posedge clock) disable iff (!rstn)
      !(clk_en && cmd.wr_en && hit(cmd) && write_set_point_select == 1'(g))
      |=> copy_reg[g] == $past(copy_reg[g]))
      else $error("copy moved without its write");
  end

  // Frozen enable: answers and active setting hold still
  a_freeze_hold: assert property (@(posedge clock) disable iff (!rstn)
    !clk_en |=> $stable(rd_data) && $stable(rd_valid) && $stable(active_cfg))
    else $error("state moved while frozen");

  // Active path: follows the operating copy one edge later
  a_active_copy: assert property (@(posedge clock) disable iff (!rstn)
    clk_en |=> active_cfg == $past(copy_reg[operating_set_point_select]))
    else $error("active not from operating copy");
  // A write to the inactive copy, operating select steady, leaves active alone
  a_inactive_ignored: assert property (@(posedge clock) disable iff (!rstn)
    (clk_en && cmd.wr_en && hit(cmd) && write_set_point_select != operating_set_point_select)
    ##1 (clk_en && $stable(operating_set_point_select)) |=> $stable(active_cfg))
    else $error("inactive write moved active");

  // Decode: span limits and fixed points checked as numbers, not as the sum
  a_level_range: assert property (@(posedge clock) disable iff (!rstn)
    active_code_valid |-> active_level_tenths <= (active_cfg.range_sel ? 10'h1A4 : 10'h12C))
    else $error("level out of span");
  a_floor_level: assert property (@(posedge clock) disable iff (!rstn)
    active_cfg == ref_cfg_s'(7'h00) |-> active_level_tenths == 10'h064)
    else $error("range 0 floor not 10.0 percent");
  a_range0_top: assert property (@(posedge clock) disable iff (!rstn)
    active_cfg == ref_cfg_s'(7'h32) |-> active_level_tenths == 10'h12C)
    else $error("range 0 top not 30.0 percent");
  a_default_level: assert property (@(posedge clock) disable iff (!rstn)
    active_cfg == ref_cfg_s'(7'h4D) |-> active_level_tenths == 10'h110)
    else $error("default level not 27.2 percent");
  a_range1_top: assert property (@(posedge clock) disable iff (!rstn)
    active_cfg == ref_cfg_s'(7'h72) |-> active_level_tenths == 10'h1A4)
    else $error("range 1 top not 42.0 percent");
  // Reserved codes are flagged and give the range base only
  a_code_valid: assert property (@(posedge clock) disable iff (!rstn)
    active_code_valid == (active_cfg.level <= LEVEL_CODE_MAX))
    else $error("validity wrong");
  a_reserved_base: assert property (@(posedge clock) disable iff (!rstn)
    !active_code_valid
    |-> active_level_tenths == (active_cfg.range_sel ? RANGE1_BASE_TENTHS : RANGE0_BASE_TENTHS))
    else $error("reserved code not at base");

  // Reset: both copies and the active setting start at the default
  a_reset_value: assert property (@(posedge clock)
    $rose(rstn) |-> copy_reg[0] == 7'h4D && copy_reg[1] == 7'h4D)
    else $error("reset value wrong");
  a_reset_active: assert property (@(posedge clock)
    $rose(rstn) |-> active_cfg == ref_cfg_s'(REG_RESET[6:0]))
    else $error("reset active setting wrong");

  // Main scenarios
  c_write_point1: cover property (@(posedge clock) disable iff (!rstn)
    clk_en && cmd.wr_en && hit(cmd) && write_set_point_select);
  c_read_back: cover property (@(posedge clock) disable iff (!rstn) rd_valid);
  c_switch_op: cover property (@(posedge clock) disable iff (!rstn)
    $changed(operating_set_point_select));
  c_range0: cover property (@(posedge clock) disable iff (!rstn) !active_cfg.range_sel);
  c_reserved_code: cover property (@(posedge clock) disable iff (!rstn)
    active_cfg.level > LEVEL_CODE_MAX);
endmodule : dq_reference_level_ctrl

/* File: sim/mr_ctrl_model.sv */
// Purpose: Controller model issuing mode register commands.
// Assumes: One command in flight at a time.
// Notes: Each command is followed by one idle edge.
`timescale 1ns/10ps
module mr_ctrl_model (
  // Clock
  input wire logic clock,
  // Command side
  output dq_ref_pkg::mr_cmd_s cmd,
  output logic write_set_point_select,
  output logic operating_set_point_select,
  // Read answer
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  import dq_ref_pkg::*;
  // Idle command and set point zero from time zero
  initial begin
    cmd = '0;
    write_set_point_select = 1'b0;
    operating_set_point_select = 1'b0;
  end
  // Select bits settle a full cycle before use; called just at an edge
  task automatic sel(input logic w, input logic o);
    write_set_point_select <= w;
    operating_set_point_select <= o;
    @(posedge clock);
  endtask : sel
  // Range and level always travel in one byte
  // The answer stands one cycle, so it is taken at the edge that ends it
  task automatic issue(input logic w, input logic [5:0] a, input logic [7:0] d,
      output logic v, output logic [7:0] q);
    cmd <= '{w, ~w, a, d};
    @(posedge clock);
    cmd <= '0;
    @(posedge clock);
    v = rd_valid;
    q = rd_data;
  endtask : issue
endmodule : mr_ctrl_model

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the reference level register.
// Assumes: The controller model issues every command.
// Notes: Expected levels are in tenths of a percent.
`timescale 1ns/10ps
module testbench;
  import dq_ref_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  mr_cmd_s cmd;
  logic wsel, osel, rd_valid, code_ok;
  logic [7:0] rd_data, q;
  ref_cfg_s cfg;
  logic [9:0] tenths;
  int bad_count = 0;
  int num_checks = 0;
  always #25 clock = ~clock;
  mr_ctrl_model mr_ctrl_model_inst (.clock(clock), .cmd(cmd), .write_set_point_select(wsel),
    .operating_set_point_select(osel), .rd_data(rd_data), .rd_valid(rd_valid));
  dq_reference_level_ctrl dq_reference_level_ctrl_inst (.clock(clock), .rstn(rstn),
    .clk_en(clk_en), .cmd(cmd), .write_set_point_select(wsel),
    .operating_set_point_select(osel), .rd_data(rd_data), .rd_valid(rd_valid),
    .active_cfg(cfg), .active_level_tenths(tenths), .active_code_valid(code_ok));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read one copy and expect a one-cycle answer
  task automatic rdchk(input logic w, input logic [7:0] exp);
    logic v;
    mr_ctrl_model_inst.sel(w, osel);
    mr_ctrl_model_inst.issue(1'b0, 6'h0E, 8'h00, v, q);
    chk({v, q}, {1'b1, exp});
  endtask : rdchk
  // Write, then one more edge so the active copy has caught up
  task automatic wr(input logic [7:0] d);
    logic v;
    mr_ctrl_model_inst.issue(1'b1, 6'h0E, d, v, q);
    @(posedge clock);
  endtask : wr
  task automatic t_reset;
    chk({cfg, tenths, code_ok}, {7'h4D, 10'h110, 1'b1});
    rdchk(1'b0, 8'h4D);
    rdchk(1'b1, 8'h4D);
  endtask : t_reset
  // Bit 7 written high must read back low
  task automatic t_banks;
    mr_ctrl_model_inst.sel(1'b1, 1'b0);
    wr(8'hF2);
    chk({cfg, tenths}, {7'h4D, 10'h110});
    rdchk(1'b1, 8'h72);
    rdchk(1'b0, 8'h4D);
    mr_ctrl_model_inst.sel(1'b1, 1'b1);
    @(posedge clock);
    chk({cfg, tenths, code_ok}, {7'h72, 10'h1A4, 1'b1});
  endtask : t_banks
  task automatic t_range0;
    mr_ctrl_model_inst.sel(1'b0, 1'b0);
    wr(8'h00);
    chk({cfg, tenths}, {7'h00, 10'h064});
    wr(8'h32);
    chk({cfg, tenths, code_ok}, {7'h32, 10'h12C, 1'b1});
    wr(8'h33);
    chk({cfg, code_ok}, {7'h33, 1'b0});
    rdchk(1'b1, 8'h72);
  endtask : t_range0
  // Foreign-address read gets no answer; frozen clock enable leaves the copy alone
  task automatic t_refuse;
    logic v;
    mr_ctrl_model_inst.issue(1'b0, 6'h0D, 8'h00, v, q);
    chk({v, q}, 9'h000);
    @(posedge clock) clk_en <= 1'b0;
    wr(8'h11);
    @(posedge clock) clk_en <= 1'b1;
    rdchk(1'b1, 8'h72);
  endtask : t_refuse
  task automatic t_rst_mid;
    @(posedge clock) rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    chk({cfg, tenths}, {7'h4D, 10'h110});
    rdchk(1'b1, 8'h4D);
  endtask : t_rst_mid
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_banks();
    t_range0();
    t_refuse();
    t_rst_mid();
    test_done();
  end
  // Hang guard well above the run length
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : testbench
